// ==== hw/synth_cfg_pkg.sv ====
// Constants and carrier types for the serial configuration port.
// Assumes a single system clock; the port synchronises the serial pins itself.
package synth_cfg_pkg;
  localparam int WORD_BITS = 11;
  localparam int PAYLOAD_BITS = 9;
  localparam int ADDR_LSB = 0;
  localparam int PAYLOAD_LSB = 2;
  localparam logic [1:0] ADDR_REF_PUMP = 2'h0;
  localparam logic [1:0] ADDR_FB_PD = 2'h1;
  localparam logic [1:0] ADDR_PRESCALE = 2'h2;
  localparam logic [1:0] ADDR_TXPOWER = 2'h3;
  // Payload field positions (payload bit n sits at index n-1)
  localparam int REF_DIV_LSB = 0;
  localparam int REF_DIV_W = 6;
  localparam int PUMP_LSB = 6;
  localparam int PUMP_W = 2;
  localparam int PULSE_LSB = 0;
  localparam int PULSE_W = 8;
  localparam int PD_BIT = 8;
  localparam logic [5:0] REF_DIV_RESET = 6'h0A;
  localparam logic [1:0] PUMP_RESET = 2'h0;
  localparam logic [7:0] PULSE_RESET = 8'h80;
  localparam logic PD_RESET = 1'b0;

  typedef struct packed {
    logic [5:0] ref_div;
    logic [1:0] pump_sel;
  } ref_pump_s;

  typedef struct packed {
    logic [7:0] pulse_count;
    logic power_down;
  } fb_pd_s;
endpackage : synth_cfg_pkg

// ==== hw/edge_sync.sv ====
// Two-flop synchroniser with rising edge detect on the synchronised level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule : edge_sync
`default_nettype wire

// ==== hw/synth_serial_config_port.sv ====
// Serial programming port: shift register and two decoded holding latches.
// Serial clock, data and strobe come from an outside host and are sampled by clk.
// Functional notes
// - Data is captured into the shift register on each rising serial clock edge.
// - Words arrive most significant bit first, so each new bit shifts in at the bottom.
// - A rising latch strobe copies the shift register into the addressed latch.
// - The word that is transferred is the last 11 bits shifted.
// - The two last bits address the latch, code 0 divider/pump and code 1 feedback/power-down.
// - Divider payload bits one to six give the reference divide, zero meaning divide by one.
// - Divider payload bits eight and seven select the charge-pump current.
// - Divider payload bit nine is ignored.
// - Feedback payload bit nine set to one forces global power-down.
// - Feedback payload bits one to eight set the pulse counter.
// - The pulse counter value is binary weighted, bit one weight one to bit eight weight 128.
`timescale 1ns/1ns
`default_nettype none
module synth_serial_config_port
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe,
  output logic [5:0] ref_divide,
  output logic [6:0] ref_divide_eff,
  output logic [1:0] pump_current_sel,
  output logic [7:0] pulse_count,
  output logic power_down
);
  logic sclk_rise;
  logic data_lvl;
  logic strobe_rise;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [1:0] addr;
  logic [PAYLOAD_BITS-1:0] payload;
  ref_pump_s ref_pump_q;
  fb_pd_s fb_pd_q;
  logic ref_load;
  logic fb_load;
  logic [6:0] ref_div_eff_q;

  // A zero code divides by one, so the ratio never reads as zero
  function automatic logic [6:0] divide_ratio(input logic [5:0] code);
    divide_ratio = (code == 6'h00) ? 7'h01 : {1'b0, code};
  endfunction : divide_ratio

  function automatic logic latch_hit(input logic [1:0] code, input logic [1:0] target);
    latch_hit = (code == target);
  endfunction : latch_hit

  edge_sync u_sclk (
    .clk(clk),
    .rst(rst),
    .din(serial_clk),
    .level(),
    .rise(sclk_rise)
  );

  edge_sync u_data (
    .clk(clk),
    .rst(rst),
    .din(serial_data),
    .level(data_lvl),
    .rise()
  );

  edge_sync u_le (
    .clk(clk),
    .rst(rst),
    .din(latch_strobe),
    .level(),
    .rise(strobe_rise)
  );

  // Data is sampled alongside the clock edge; host setup time dwarfs the sync delay
  assign shift_d = {shift_q[WORD_BITS-2:0], data_lvl};

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
    end
  end

  assign addr = shift_q[ADDR_LSB +: 2];
  assign payload = shift_q[WORD_BITS-1:PAYLOAD_LSB];
  assign ref_load = strobe_rise && latch_hit(addr, ADDR_REF_PUMP);
  assign fb_load = strobe_rise && latch_hit(addr, ADDR_FB_PD);

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_pump_q.ref_div <= REF_DIV_RESET;
    end else if (ref_load) begin
      ref_pump_q.ref_div <= payload[REF_DIV_LSB +: REF_DIV_W];
    end
  end

  // Effective ratio sits in a flop so the output never glitches through the decode
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_div_eff_q <= {1'b0, REF_DIV_RESET};
    end else if (ref_load) begin
      ref_div_eff_q <= divide_ratio(payload[REF_DIV_LSB +: REF_DIV_W]);
    end
  end

  // Payload bit nine of this latch has no use and is dropped here
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_pump_q.pump_sel <= PUMP_RESET;
    end else if (ref_load) begin
      ref_pump_q.pump_sel <= payload[PUMP_LSB +: PUMP_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fb_pd_q.pulse_count <= PULSE_RESET;
    end else if (fb_load) begin
      fb_pd_q.pulse_count <= payload[PULSE_LSB +: PULSE_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fb_pd_q.power_down <= PD_RESET;
    end else if (fb_load) begin
      fb_pd_q.power_down <= payload[PD_BIT];
    end
  end

  assign ref_divide = ref_pump_q.ref_div;
  assign ref_divide_eff = ref_div_eff_q;
  assign pump_current_sel = ref_pump_q.pump_sel;
  assign pulse_count = fb_pd_q.pulse_count;
  assign power_down = fb_pd_q.power_down;

  shift_bit_a: assert property (@(posedge clk) disable iff (rst)
    sclk_rise
    |=> shift_q[0] == $past(data_lvl))
    else $error("shift register missed serial bit");

  shift_order_a: assert property (@(posedge clk) disable iff (rst)
    sclk_rise
    |=> shift_q[WORD_BITS-1:1] == $past(shift_q[WORD_BITS-2:0]))
    else $error("shift order wrong");

  shift_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sclk_rise
    |=> $stable(shift_q))
    else $error("shift register moved without serial clock");

  ref_load_a: assert property (@(posedge clk) disable iff (rst)
    ref_load
    |=> ref_divide == $past(payload[REF_DIV_LSB +: REF_DIV_W]))
    else $error("divider latch not loaded");

  pump_load_a: assert property (@(posedge clk) disable iff (rst)
    ref_load
    |=> pump_current_sel == $past(payload[PUMP_LSB +: PUMP_W]))
    else $error("pump select not loaded");

  fb_load_a: assert property (@(posedge clk) disable iff (rst)
    fb_load
    |=> pulse_count == $past(payload[PULSE_LSB +: PULSE_W]))
    else $error("pulse count not loaded");

  pulse_weight_a: assert property (@(posedge clk) disable iff (rst)
    fb_load
    |=> pulse_count[0] == $past(payload[PULSE_LSB]) && pulse_count[PULSE_W-1] == $past(payload[PULSE_LSB+PULSE_W-1]))
    else $error("pulse count weights wrong");

  pd_load_a: assert property (@(posedge clk) disable iff (rst)
    fb_load
    |=> power_down == $past(payload[PD_BIT]))
    else $error("power down not loaded");

  word_load_a: assert property (@(posedge clk) disable iff (rst)
    fb_load
    |=> {power_down, pulse_count} == $past(shift_q[WORD_BITS-1:PAYLOAD_LSB]))
    else $error("word not transferred whole");

  div_one_a: assert property (@(posedge clk) disable iff (rst)
    ref_divide == 6'h00
    |-> ref_divide_eff == 7'h01)
    else $error("zero divide not one");

  eff_track_a: assert property (@(posedge clk) disable iff (rst)
    ref_divide != 6'h00
    |-> ref_divide_eff == {1'b0, ref_divide})
    else $error("effective divide differs from code");

  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    !strobe_rise
    |=> $stable(ref_divide) && $stable(ref_divide_eff) && $stable(pump_current_sel) && $stable(pulse_count) && $stable(power_down))
    else $error("latch changed without strobe");

  ref_other_a: assert property (@(posedge clk) disable iff (rst)
    strobe_rise && !latch_hit(addr, ADDR_REF_PUMP)
    |=> $stable(ref_divide) && $stable(ref_divide_eff) && $stable(pump_current_sel))
    else $error("divider latch changed on other address");

  fb_other_a: assert property (@(posedge clk) disable iff (rst)
    strobe_rise && !latch_hit(addr, ADDR_FB_PD)
    |=> $stable(pulse_count) && $stable(power_down))
    else $error("feedback latch changed on other address");

  reset_div_a: assert property (@(posedge clk)
    rst
    |=> ref_divide == REF_DIV_RESET && ref_divide_eff == {1'b0, REF_DIV_RESET})
    else $error("divider reset not ten");

  pump_reset_a: assert property (@(posedge clk)
    rst
    |=> pump_current_sel == PUMP_RESET)
    else $error("pump select reset wrong");

  fb_reset_a: assert property (@(posedge clk)
    rst
    |=> pulse_count == PULSE_RESET && power_down == PD_RESET)
    else $error("feedback latch reset wrong");
endmodule : synth_serial_config_port
`default_nettype wire

// ==== verif/cfg_host.sv ====
// Host model: drives serial clock, data and latch strobe of the config port.
// Assumes serial timing far slower than the sampling clock of the port.
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
  output var logic serial_clk,
  output var logic serial_data,
  output var logic latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Clock idles low between frames; 125 ns period, phase free of clk
  task automatic send(input logic [10:0] w, input logic strobe);
    for (int i = 10; i >= 0; i--) begin
      serial_data = w[i];
      #62 serial_clk = 1'b1;
      #63 serial_clk = 1'b0;
    end
    // Released line shows the inverse so a stale bit cannot pass for data
    serial_data = ~w[0];
    #125 latch_strobe = strobe;
    #125 latch_strobe = 1'b0;
    #250;
  endtask : send
endmodule : cfg_host
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the serial configuration port.
// Assumes the host model above supplies all serial traffic.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import synth_cfg_pkg::*;
  logic clk, rst;
  wire logic serial_clk, serial_data, latch_strobe;
  logic [5:0] ref_divide;
  logic [6:0] ref_divide_eff;
  logic [1:0] pump_current_sel;
  logic [7:0] pulse_count;
  logic power_down;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] e_ref = {2'h0, REF_DIV_RESET};
  logic [7:0] e_pump = 8'h00;
  logic [7:0] e_pulse = PULSE_RESET;
  logic [7:0] e_pd = 8'h00;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cfg_host host (.serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe));
  synth_serial_config_port DUT (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_strobe(latch_strobe), .ref_divide(ref_divide),
    .ref_divide_eff(ref_divide_eff), .pump_current_sel(pump_current_sel),
    .pulse_count(pulse_count), .power_down(power_down));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic check_all();
    chk({2'h0, ref_divide}, e_ref);
    chk({1'b0, ref_divide_eff}, (e_ref == 8'h00) ? 8'h01 : e_ref);
    chk({6'h00, pump_current_sel}, e_pump);
    chk(pulse_count, e_pulse);
    chk({7'h00, power_down}, e_pd);
  endtask : check_all
  task automatic wr(input logic [1:0] a, input logic [8:0] p, input logic s);
    host.send({p, a}, s);
    if (s && a == ADDR_REF_PUMP) begin
      e_ref = {2'h0, p[5:0]};
      e_pump = {6'h00, p[7:6]};
    end
    if (s && a == ADDR_FB_PD) begin
      e_pulse = p[7:0];
      e_pd = {7'h00, p[8]};
    end
    check_all();
  endtask : wr
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    check_all();
    $display("test reset done");
    for (int i = 0; i < 4; i++) wr(ADDR_REF_PUMP, {i[0], i[1:0], 6'(i * 21)}, 1'b1);
    $display("test divider and pump done");
    wr(ADDR_FB_PD, 9'h1A5, 1'b1);
    wr(ADDR_FB_PD, 9'h0FF, 1'b1);
    wr(ADDR_FB_PD, 9'h101, 1'b0);
    $display("test feedback and power-down done");
    wr(ADDR_PRESCALE, 9'h155, 1'b1);
    wr(ADDR_TXPOWER, 9'h0AA, 1'b1);
    $display("test unused addresses done");
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    e_ref = {2'h0, REF_DIV_RESET};
    e_pump = {6'h00, PUMP_RESET};
    e_pulse = PULSE_RESET;
    e_pd = {7'h00, PD_RESET};
    check_all();
    wr(ADDR_REF_PUMP, 9'h1C5, 1'b1);
    $display("test mid-run reset done");
    print_verdict();
  end
  // Ten words take about 19 us; allow about ten times that
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
